// ### verilog/vpo_top.sv
// pixel output port: 8/16-bit 4:2:2 formatter, chroma swap and clock pin select
`timescale 1ns/1ps
`include "vpo_defines.svh"
module vpo_top
    import vpo_pkg::*;
(
    input wire logic clk_sys, // 100 MHz system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_we, // write strobe
    input wire logic reg_re, // read strobe
    output logic [7:0] reg_rdata_q, // read data, valid the cycle after reg_re
    input wire logic llc_pin, // line-locked full-rate clock from the pin
    input wire logic pixel_clock_polarity, // clock polarity pin
    input wire logic [7:0] src_y0, // first luma of the next pair
    input wire logic [7:0] src_y1, // second luma of the next pair
    input wire logic [7:0] src_cb, // Cb of the next pair
    input wire logic [7:0] src_cr, // Cr of the next pair
    output logic src_take_q, // pulse: pair inputs were captured
    output logic [15:0] pix_q, // pixel data bus
    output logic pix_oe_hi_q, // drive enable for bits 15:8
    output logic pix_oe_lo_q, // drive enable for bits 7:0
    output logic main_pixel_clock_pin_q, // selected clock on the main pin
    output logic half_rate_pixel_clock_q // half-rate clock
);
    logic [7:0] fmt_reg_q; // output_format_control
    logic [7:0] chroma_reg_q; // chroma_order_control
    logic [7:0] clksrc_reg_q; // clock_pin_source_control
    logic llc_lvl; // filtered link clock level
    logic tick; // full-rate tick: link clock rose
    logic pol_lvl; // filtered polarity pin
    vpo_phase_t phase_q; // current slot
    logic tick_d_q; // tick delayed one cycle, output update moment
    logic llc_d_q; // link level aligned with tick_d_q
    logic mode16_q; // 16-bit mode latched per pair
    logic swap_q; // chroma swap latched per pair
    logic [7:0] y0_q, y1_q, cb_q, cr_q; // pair being sent
    logic half_n; // half-rate clock level for the current slot
    logic [`VPO_IDLE_W-1:0] idle_q; // cycles since the last tick
    logic [3:0] output_format_select; // format field
    logic [2:0] clock_pin_source_select; // clock source field

    assign output_format_select = fmt_reg_q[`VPO_FMT_MSB:`VPO_FMT_LSB];
    assign clock_pin_source_select = clksrc_reg_q[`VPO_CLKSRC_MSB:`VPO_CLKSRC_LSB];

    // high in slots where a word carrying luma begins
    function automatic logic luma_edge(input vpo_phase_t ph, input logic m16);
        if (m16) begin
            luma_edge = (ph == VPO_PH_CB) || (ph == VPO_PH_CR);
        end else begin
            luma_edge = (ph == VPO_PH_Y0) || (ph == VPO_PH_Y1);
        end
    endfunction : luma_edge

    // chroma for the first or second half of a pair, after swap
    function automatic logic [7:0] pick_chroma(input logic swp, input logic first,
                                               input logic [7:0] cb, input logic [7:0] cr);
        pick_chroma = (first ^ swp) ? cb : cr;
    endfunction : pick_chroma

    assign half_n = luma_edge(phase_q, mode16_q);

    vpo_sync3 u_llc_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin(llc_pin),
        .level_q(llc_lvl),
        .rise_q(tick),
        .fall_q()
    );

    vpo_sync3 u_pol_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin(pixel_clock_polarity),
        .level_q(pol_lvl),
        .rise_q(),
        .fall_q()
    );

    // register writes; reserved codes are stored as written
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fmt_reg_q <= `VPO_RST_FORMAT;
            chroma_reg_q <= `VPO_RST_CHROMA;
            clksrc_reg_q <= `VPO_RST_CLKSRC;
        end else if (reg_we) begin
            case (reg_addr)
                `VPO_OFS_FORMAT: fmt_reg_q <= reg_wdata;
                `VPO_OFS_CHROMA: chroma_reg_q <= reg_wdata;
                `VPO_OFS_CLKSRC: clksrc_reg_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // register reads; unmapped addresses return zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                `VPO_OFS_FORMAT: reg_rdata_q <= fmt_reg_q;
                `VPO_OFS_CHROMA: reg_rdata_q <= chroma_reg_q;
                `VPO_OFS_CLKSRC: reg_rdata_q <= clksrc_reg_q;
                `VPO_OFS_STATUS: reg_rdata_q <= {2'h0, mode16_q, phase_q,
                                                 (idle_q < 8'(`VPO_LINK_IDLE_CYC))};
                default: reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    // link activity counter, saturating, for the status word
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            idle_q <= 8'hFF;
        end else if (tick) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'hFF) begin
            idle_q <= idle_q + 8'h01;
        end
    end

    // slot sequencer, one step per full-rate tick
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_q <= VPO_PH_Y1;
        end else if (tick) begin
            case (phase_q)
                VPO_PH_CB: phase_q <= VPO_PH_Y0;
                VPO_PH_Y0: phase_q <= VPO_PH_CR;
                VPO_PH_CR: phase_q <= VPO_PH_Y1;
                VPO_PH_Y1: phase_q <= VPO_PH_CB;
                default: phase_q <= VPO_PH_Y1;
            endcase
        end
    end

    // capture a new pair and the mode at pair boundaries, so a mode or swap
    // change never tears a pair in half
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            y0_q <= 8'h00;
            y1_q <= 8'h00;
            cb_q <= 8'h00;
            cr_q <= 8'h00;
            mode16_q <= 1'b0;
            swap_q <= 1'b0;
            src_take_q <= 1'b0;
        end else begin
            src_take_q <= tick && (phase_q == VPO_PH_Y1);
            if (tick && (phase_q == VPO_PH_Y1)) begin
                y0_q <= src_y0;
                y1_q <= src_y1;
                cb_q <= src_cb;
                cr_q <= src_cr;
                mode16_q <= (output_format_select == `VPO_FMT_16BIT);
                swap_q <= chroma_reg_q[`VPO_SWAP_BIT];
            end
        end
    end

    // alignment delay so data and clocks leave on the same edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tick_d_q <= 1'b0;
            llc_d_q <= 1'b0;
        end else begin
            tick_d_q <= tick;
            llc_d_q <= llc_lvl;
        end
    end

    // pixel bus; any code other than 16-bit runs as 8-bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pix_q <= 16'h0000;
            pix_oe_hi_q <= 1'b0;
            pix_oe_lo_q <= 1'b0;
        end else if (tick_d_q) begin
            pix_oe_hi_q <= 1'b1;
            pix_oe_lo_q <= mode16_q;
            if (mode16_q) begin
                // luma high, muxed chroma low
                case (phase_q)
                    VPO_PH_CB, VPO_PH_Y0: pix_q <= {y0_q, pick_chroma(swap_q, 1'b1, cb_q, cr_q)};
                    default: pix_q <= {y1_q, pick_chroma(swap_q, 1'b0, cb_q, cr_q)};
                endcase
            end else begin
                // interleaved samples on the high byte only
                case (phase_q)
                    VPO_PH_CB: pix_q <= {pick_chroma(swap_q, 1'b1, cb_q, cr_q), 8'h00};
                    VPO_PH_Y0: pix_q <= {y0_q, 8'h00};
                    VPO_PH_CR: pix_q <= {pick_chroma(swap_q, 1'b0, cb_q, cr_q), 8'h00};
                    default: pix_q <= {y1_q, 8'h00};
                endcase
            end
        end
    end

    // clocks; updated every cycle; the slot level moves only after a tick, the link and polarity levels at any edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            half_rate_pixel_clock_q <= 1'b0;
            main_pixel_clock_pin_q <= 1'b0;
        end else begin
            half_rate_pixel_clock_q <= half_n ^ pol_lvl;
            if (clock_pin_source_select == `VPO_CLKSRC_HALF) begin
                main_pixel_clock_pin_q <= half_n ^ pol_lvl;
            end else begin
                main_pixel_clock_pin_q <= llc_d_q ^ pol_lvl;
            end
        end
    end

    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_pair_end;
        tick && (phase_q == VPO_PH_Y1);
    endsequence
    sequence s_pair_start;
        (phase_q == VPO_PH_CB) && src_take_q;
    endsequence

    a_pair_order: assert property (s_pair_end |=> s_pair_start)
        else $error("pair did not restart at Cb");
    a_reset_format: assert property ($fell(srst) |-> output_format_select == 4'h3)
        else $error("format field not 0011 after reset");
    a_eight_low_off: assert property (tick_d_q && !mode16_q |=> !pix_oe_lo_q && pix_oe_hi_q)
        else $error("low byte driven in 8-bit mode");
    a_sixteen_split: assert property (tick_d_q && mode16_q && phase_q == VPO_PH_CR
        |=> pix_q[15:8] == y1_q && pix_oe_lo_q)
        else $error("16-bit word wrong");
    a_chroma_swap: assert property (tick_d_q && !mode16_q && phase_q == VPO_PH_CB
        |=> pix_q[15:8] == (swap_q ? cr_q : cb_q))
        else $error("chroma order wrong");
    a_main_full: assert property (clock_pin_source_select == 3'h0
        |=> main_pixel_clock_pin_q == ($past(llc_d_q) ^ $past(pol_lvl)))
        else $error("main pin not full rate");
    a_main_half: assert property (clock_pin_source_select == 3'h5
        |=> main_pixel_clock_pin_q == half_rate_pixel_clock_q)
        else $error("main pin not half rate");
    a_data_stable: assert property (!tick_d_q |=> $stable(pix_q))
        else $error("data moved off the clock");
    a_luma_rise: assert property (tick_d_q && phase_q == VPO_PH_Y0 && !mode16_q && !pol_lvl
        |=> half_rate_pixel_clock_q && pix_q[15:8] == y0_q)
        else $error("rising edge not on luma");
    a_polarity_flip: assert property (pol_lvl && $stable(pol_lvl)
        |=> half_rate_pixel_clock_q == !$past(half_n))
        else $error("clock not inverted");
endmodule : vpo_top

// ### verilog/vpo_defines.svh
// register offsets, field positions, reset values and timing counts of the pixel output port
`ifndef VPO_DEFINES_SVH
`define VPO_DEFINES_SVH

`define VPO_OFS_FORMAT 8'h03
`define VPO_OFS_CHROMA 8'h27
`define VPO_OFS_CLKSRC 8'h8F
`define VPO_OFS_STATUS 8'hF0

`define VPO_FMT_MSB 5
`define VPO_FMT_LSB 2
`define VPO_SWAP_BIT 7
`define VPO_CLKSRC_MSB 6
`define VPO_CLKSRC_LSB 4

`define VPO_RST_FORMAT 8'h0C
`define VPO_RST_CHROMA 8'h00
`define VPO_RST_CLKSRC 8'h00

`define VPO_FMT_16BIT 4'h2
`define VPO_FMT_8BIT 4'h3
`define VPO_CLKSRC_FULL 3'h0
`define VPO_CLKSRC_HALF 3'h5

`define VPO_SYS_PERIOD_NS 10
`define VPO_LINK_IDLE_NS 2000
`define VPO_LINK_IDLE_CYC (`VPO_LINK_IDLE_NS / `VPO_SYS_PERIOD_NS)
`define VPO_IDLE_W 8

`endif

// ### verilog/vpo_pkg.sv
// types shared by the pixel output port
package vpo_pkg;
    // one slot of the 4:2:2 pair sequence, one per full-rate tick
    typedef enum logic [3:0] {
        VPO_PH_CB = 4'b0001,
        VPO_PH_Y0 = 4'b0010,
        VPO_PH_CR = 4'b0100,
        VPO_PH_Y1 = 4'b1000
    } vpo_phase_t;
endpackage : vpo_pkg

// ### verilog/vpo_sync3.sv
// three-flop pin sampler with filtered level and edge pulses
`timescale 1ns/1ps
module vpo_sync3 (
    input wire logic clk_sys, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic pin, // asynchronous pin level
    output logic level_q, // filtered level
    output logic rise_q, // one-cycle pulse as level_q goes high
    output logic fall_q // one-cycle pulse as level_q goes low
);
    logic s1_q; // first stage, read only by s2_q
    logic s2_q; // second stage
    logic s3_q; // third stage

    // plain shift chain; metastability settles in s1_q
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= (s2_q == s3_q) && s3_q && !level_q;
            fall_q <= (s2_q == s3_q) && !s3_q && level_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule : vpo_sync3

// ### testbench/vpo_video_sink.sv
// downstream video receiver model: latches the pixel word on each rising clock edge while the high byte is driven
`timescale 1ns/1ps
module vpo_video_sink (
    input wire logic clk_sys, // system clock used to find pin edges
    input wire logic clk_in, // clock pin as seen by the receiver
    input wire logic oe_hi, // high byte driven by the port
    input wire logic [15:0] pix, // pixel data bus
    output logic [15:0] word_q // word latched at the last rising edge
);
    logic prev_q; // clock level one cycle back

    // a receiver keyed to the rising edge takes luma there, so latch the whole word
    always_ff @(posedge clk_sys) begin
        prev_q <= clk_in;
        if (clk_in && !prev_q && oe_hi) begin
            word_q <= pix;
        end
    end
endmodule : vpo_video_sink

// ### testbench/video_pixel_output_port_tb.sv
// self-checking bench for the pixel output port
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module video_pixel_output_port_tb;
    logic clk_sys = 1'b0; // 100 MHz system clock
    logic srst = 1'b1; // synchronous reset
    logic [7:0] reg_addr = 8'h00; // register address
    logic [7:0] reg_wdata = 8'h00; // register write data
    logic reg_we = 1'b0; // write strobe
    logic reg_re = 1'b0; // read strobe
    logic [7:0] reg_rdata_q; // read data
    logic llc_pin = 1'b0; // free-running line-locked clock
    logic pol = 1'b0; // clock polarity pin
    logic [7:0] src_y0 = 8'h1A; // first luma
    logic [7:0] src_y1 = 8'h2B; // second luma
    logic [7:0] src_cb = 8'h3C; // blue chroma
    logic [7:0] src_cr = 8'h4D; // red chroma
    logic src_take_q; // pair captured pulse
    logic [15:0] pix_q; // pixel bus
    logic pix_oe_hi_q; // high byte enable
    logic pix_oe_lo_q; // low byte enable
    logic main_pixel_clock_pin_q; // main clock pin
    logic half_rate_pixel_clock_q; // half-rate clock
    logic [15:0] sink_word; // word seen by the receiver
    int num_errors = 0; // mismatches
    int tests_run = 0; // comparisons

    // system clock, 10 ns period
    always #5 clk_sys = ~clk_sys;

    // link clock, 160 ns period, phase offset so its edges never meet clk_sys edges
    initial begin
        #3;
        forever #80 llc_pin = ~llc_pin;
    end

    vpo_top dut_u (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .llc_pin(llc_pin),
        .pixel_clock_polarity(pol), .src_y0(src_y0), .src_y1(src_y1), .src_cb(src_cb),
        .src_cr(src_cr), .src_take_q(src_take_q), .pix_q(pix_q), .pix_oe_hi_q(pix_oe_hi_q),
        .pix_oe_lo_q(pix_oe_lo_q), .main_pixel_clock_pin_q(main_pixel_clock_pin_q),
        .half_rate_pixel_clock_q(half_rate_pixel_clock_q));

    vpo_video_sink sink_u (.clk_sys(clk_sys), .clk_in(main_pixel_clock_pin_q),
        .oe_hi(pix_oe_hi_q), .pix(pix_q), .word_q(sink_word));

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask : reg_write

    // one-cycle read strobe, data judged in the following cycle only
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1;
        `CHK(reg_rdata_q, exp)
    endtask : reg_read

    // bounded wait for the pair-capture pulse
    task automatic wait_take;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (src_take_q !== 1'b1 && n < 200);
        `CHK(src_take_q, 1'b1)
    endtask : wait_take

    // follows one pair over four ticks, one tick every 16 system cycles
    task automatic check_pair(input bit m16, input bit sw, input bit p, input bit hsel);
        logic [7:0] c0;
        logic [7:0] c1;
        logic [7:0] b;
        logic h;
        logic [15:0] w;
        c0 = sw ? src_cr : src_cb;
        c1 = sw ? src_cb : src_cr;
        wait_take();
        for (int k = 0; k < 4; k++) begin
            if (k == 0) @(posedge clk_sys);
            else repeat (6) @(posedge clk_sys);
            #1;
            h = ((k % 2 == 0) ~^ m16) ^ p;
            b = (k == 0) ? c0 : (k == 2) ? c1 : (k == 1) ? src_y0 : src_y1;
            `CHK(half_rate_pixel_clock_q, h)
            `CHK(main_pixel_clock_pin_q, hsel ? h : ~p)
            `CHK(pix_oe_hi_q, 1'b1)
            `CHK(pix_oe_lo_q, m16)
            if (m16) `CHK(pix_q, (k < 2) ? {src_y0, c0} : {src_y1, c1})
            else `CHK(pix_q[15:8], b)
            w = pix_q;
            // second look late in the slot: full-rate clock in its low half, data held
            repeat (10) @(posedge clk_sys);
            #1;
            `CHK(half_rate_pixel_clock_q, h)
            `CHK(main_pixel_clock_pin_q, hsel ? h : p)
            `CHK(pix_q, w)
        end
    endtask : check_pair

    // reset values and an unmapped read
    task automatic t_reset_regs;
        reg_read(8'h03, 8'h0C);
        reg_read(8'h27, 8'h00);
        reg_read(8'h8F, 8'h00);
        reg_read(8'h10, 8'h00);
    endtask : t_reset_regs

    // default 8-bit stream
    task automatic t_default8;
        check_pair(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_default8

    // chroma swap, settings take effect at a pair boundary so one pair is skipped
    task automatic t_swap8;
        reg_write(8'h27, 8'h80);
        reg_read(8'h27, 8'h80);
        wait_take();
        check_pair(1'b0, 1'b1, 1'b0, 1'b0);
        reg_write(8'h27, 8'h00);
    endtask : t_swap8

    // wide mode, only documented codes are written
    task automatic t_wide16;
        reg_write(8'h03, 8'h08);
        wait_take();
        // status just after a capture: 16-bit, slot Cb, link active
        reg_read(8'hF0, 8'h23);
        check_pair(1'b1, 1'b0, 1'b0, 1'b0);
    endtask : t_wide16

    // half-rate clock on the main pin, receiver latches luma at rising edges
    task automatic t_clksel;
        reg_write(8'h8F, 8'h50);
        wait_take();
        check_pair(1'b1, 1'b0, 1'b0, 1'b1);
        `CHK(sink_word, {src_y1, src_cr})
    endtask : t_clksel

    // inverted clocks, then back to the reset configuration
    task automatic t_polarity;
        @(posedge clk_sys);
        pol <= 1'b1;
        wait_take();
        check_pair(1'b1, 1'b0, 1'b1, 1'b1);
        // new pair values, taken only at the next pair boundary
        @(posedge clk_sys);
        pol <= 1'b0;
        src_y0 <= 8'h5E;
        src_y1 <= 8'h6F;
        src_cb <= 8'h70;
        src_cr <= 8'h81;
        reg_write(8'h03, 8'h0C);
        reg_write(8'h8F, 8'h00);
        wait_take();
        check_pair(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_polarity

    // reset in mid-run after non-default writes; first pair after it may be short
    task automatic t_midreset;
        reg_write(8'h03, 8'h08);
        reg_write(8'h27, 8'h80);
        reg_write(8'h8F, 8'h50);
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        `CHK({pix_oe_hi_q, pix_oe_lo_q}, 2'b00)
        reg_read(8'hF0, 8'h10);
        t_reset_regs();
        wait_take();
        check_pair(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : t_midreset

    // counts, verdict and end of run
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset_regs();
        t_default8();
        t_swap8();
        t_wide16();
        t_clksel();
        t_polarity();
        t_midreset();
        results();
    end

    // watchdog, well beyond the roughly 980 cycles the scenarios need
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        results();
    end
endmodule : video_pixel_output_port_tb
